// *** bpc_regs.vh ***
// Register indices, field positions, masks and reset values for the buck pair config bank
`ifndef BPC_REGS_VH
`define BPC_REGS_VH

// Register indices; byte address on APB is four times the index
`define BPC_IDX_PAIR_SLEEP     6'h22
`define BPC_IDX_PAIR_MODE      6'h23
`define BPC_IDX_PAIR_CONF      6'h24
`define BPC_IDX_SINGLE_RUN     6'h2E
`define BPC_IDX_SINGLE_STBY    6'h2F
`define BPC_IDX_SINGLE_SLEEP   6'h30
`define BPC_IDX_SINGLE_MODE    6'h31
`define BPC_IDX_SINGLE_CONF    6'h32
`define BPC_IDX_STATUS         6'h33

// Writable bit masks
`define BPC_MASK_VOLT          8'h3F
`define BPC_MASK_MODE          8'h2F
`define BPC_MASK_CONF          8'hFF

// Reset values
`define BPC_RST_VOLT           8'h00
`define BPC_RST_MODE           8'h00
`define BPC_RST_CONF           8'h00

// Field positions
`define BPC_VOLT_MSB           5
`define BPC_MODE_SEL_MSB       3
`define BPC_MODE_SLEEP_BIT     5
`define BPC_CONF_ILIM_BIT      0
`define BPC_CONF_SPARE_BIT     1
`define BPC_CONF_FREQ_LSB      2
`define BPC_CONF_PHASE_LSB     4
`define BPC_CONF_SLEW_LSB      6

// Voltage code to millivolts
`define BPC_VBASE_MV           11'h12C
`define BPC_VSTEP_MV           11'h019
// Highest code at or below 0.6 V
`define BPC_VLOW_MAX_CODE      6'h0C

`endif

// *** bpc_byte_reg.v ***
// One 8-bit configuration register with a writable-bit mask
`timescale 1ns/1ps

module bpc_byte_reg #(
  parameter [7:0] WMASK = 8'hFF,
  parameter [7:0] RST   = 8'h00
) (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Write port
  input  wire       wr_en,
  input  wire [7:0] wdata,
  // Stored value
  output reg  [7:0] q
);

  // Bits outside the mask stay zero whatever is written
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else if (wr_en) begin
      q <= wdata & WMASK;
    end
  end

endmodule // bpc_byte_reg

// *** bpc_config_regs.v ***
// APB register bank for the dual-phase and single buck channel settings
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "bpc_regs.vh"

module bpc_config_regs (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Dual-phase channel settings
  output wire [5:0]  pair_sleep_volt_code,
  output wire [10:0] pair_sleep_mv,
  output wire [3:0]  pair_switch_mode_sel,
  output wire        pair_sleep_behaviour,
  output wire        pair_current_limit_sel,
  output wire [1:0]  pair_freq_code,
  output wire [1:0]  pair_phase_code,
  output wire [1:0]  pair_slew_code,
  // Single channel settings
  output wire [5:0]  single_run_volt_code,
  output wire [10:0] single_run_mv,
  output wire [5:0]  single_standby_volt_code,
  output wire [10:0] single_standby_mv,
  output wire [5:0]  single_sleep_volt_code,
  output wire [10:0] single_sleep_mv,
  output wire [3:0]  single_switch_mode_sel,
  output wire        single_sleep_behaviour,
  output wire        single_current_limit_sel,
  output wire [1:0]  single_freq_code,
  output wire [1:0]  single_phase_code,
  output wire [1:0]  single_slew_code
);

  // Bus phase decode
  wire       setup_phase;
  wire       access_phase;
  wire       aligned;
  wire [5:0] idx;
  wire       wr_cycle;

  // Register contents
  wire [7:0] pair_sleep_q;
  wire [7:0] pair_mode_q;
  wire [7:0] pair_conf_q;
  wire [7:0] single_run_q;
  wire [7:0] single_stby_q;
  wire [7:0] single_sleep_q;
  wire [7:0] single_mode_q;
  wire [7:0] single_conf_q;

  // Write strobes
  wire       wr_pair_sleep;
  wire       wr_pair_mode;
  wire       wr_pair_conf;
  wire       wr_single_run;
  wire       wr_single_stby;
  wire       wr_single_sleep;
  wire       wr_single_mode;
  wire       wr_single_conf;

  // Voltage channels gathered for the converter loop
  wire [3:0]  volt_wr;
  wire [23:0] volt_code_bus;
  wire [43:0] volt_mv_bus;
  wire [3:0]  volt_low;
  wire [7:0]  status_q;

  // Read path
  reg        hit;
  reg  [7:0] rd_mux;

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign aligned      = (paddr[1:0] == 2'h0);
  assign idx          = paddr[7:2];
  // Zero wait states: every access completes in its first access cycle
  assign pready       = 1'b1;
  assign wr_cycle     = access_phase & pwrite & aligned;

  assign wr_pair_sleep   = wr_cycle & (idx == `BPC_IDX_PAIR_SLEEP);
  assign wr_pair_mode    = wr_cycle & (idx == `BPC_IDX_PAIR_MODE);
  assign wr_pair_conf    = wr_cycle & (idx == `BPC_IDX_PAIR_CONF);
  assign wr_single_run   = wr_cycle & (idx == `BPC_IDX_SINGLE_RUN);
  assign wr_single_stby  = wr_cycle & (idx == `BPC_IDX_SINGLE_STBY);
  assign wr_single_sleep = wr_cycle & (idx == `BPC_IDX_SINGLE_SLEEP);
  assign wr_single_mode  = wr_cycle & (idx == `BPC_IDX_SINGLE_MODE);
  assign wr_single_conf  = wr_cycle & (idx == `BPC_IDX_SINGLE_CONF);

  // Dual-phase channel registers
  bpc_byte_reg #(
    .WMASK (`BPC_MASK_VOLT),
    .RST   (`BPC_RST_VOLT)
  ) u_pair_sleep (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_pair_sleep),
    .wdata   (pwdata[7:0]),
    .q       (pair_sleep_q)
  );

  bpc_byte_reg #(
    .WMASK (`BPC_MASK_MODE),
    .RST   (`BPC_RST_MODE)
  ) u_pair_mode (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_pair_mode),
    .wdata   (pwdata[7:0]),
    .q       (pair_mode_q)
  );

  bpc_byte_reg #(
    .WMASK (`BPC_MASK_CONF),
    .RST   (`BPC_RST_CONF)
  ) u_pair_conf (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_pair_conf),
    .wdata   (pwdata[7:0]),
    .q       (pair_conf_q)
  );

  // Single channel registers
  bpc_byte_reg #(
    .WMASK (`BPC_MASK_VOLT),
    .RST   (`BPC_RST_VOLT)
  ) u_single_run (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_single_run),
    .wdata   (pwdata[7:0]),
    .q       (single_run_q)
  );

  bpc_byte_reg #(
    .WMASK (`BPC_MASK_VOLT),
    .RST   (`BPC_RST_VOLT)
  ) u_single_stby (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_single_stby),
    .wdata   (pwdata[7:0]),
    .q       (single_stby_q)
  );

  bpc_byte_reg #(
    .WMASK (`BPC_MASK_VOLT),
    .RST   (`BPC_RST_VOLT)
  ) u_single_sleep (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_single_sleep),
    .wdata   (pwdata[7:0]),
    .q       (single_sleep_q)
  );

  bpc_byte_reg #(
    .WMASK (`BPC_MASK_MODE),
    .RST   (`BPC_RST_MODE)
  ) u_single_mode (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_single_mode),
    .wdata   (pwdata[7:0]),
    .q       (single_mode_q)
  );

  bpc_byte_reg #(
    .WMASK (`BPC_MASK_CONF),
    .RST   (`BPC_RST_CONF)
  ) u_single_conf (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_single_conf),
    .wdata   (pwdata[7:0]),
    .q       (single_conf_q)
  );

  // Dual-phase field breakout
  assign pair_sleep_volt_code   = pair_sleep_q[`BPC_VOLT_MSB:0];
  assign pair_switch_mode_sel   = pair_mode_q[`BPC_MODE_SEL_MSB:0];
  assign pair_sleep_behaviour   = pair_mode_q[`BPC_MODE_SLEEP_BIT];
  assign pair_current_limit_sel = pair_conf_q[`BPC_CONF_ILIM_BIT];
  assign pair_freq_code         = pair_conf_q[`BPC_CONF_FREQ_LSB +: 2];
  assign pair_phase_code        = pair_conf_q[`BPC_CONF_PHASE_LSB +: 2];
  assign pair_slew_code         = pair_conf_q[`BPC_CONF_SLEW_LSB +: 2];

  // Single channel field breakout
  assign single_run_volt_code     = single_run_q[`BPC_VOLT_MSB:0];
  assign single_standby_volt_code = single_stby_q[`BPC_VOLT_MSB:0];
  assign single_sleep_volt_code   = single_sleep_q[`BPC_VOLT_MSB:0];
  assign single_switch_mode_sel   = single_mode_q[`BPC_MODE_SEL_MSB:0];
  assign single_sleep_behaviour   = single_mode_q[`BPC_MODE_SLEEP_BIT];
  assign single_current_limit_sel = single_conf_q[`BPC_CONF_ILIM_BIT];
  assign single_freq_code         = single_conf_q[`BPC_CONF_FREQ_LSB +: 2];
  assign single_phase_code        = single_conf_q[`BPC_CONF_PHASE_LSB +: 2];
  assign single_slew_code         = single_conf_q[`BPC_CONF_SLEW_LSB +: 2];

  // Voltage channel order: pair sleep, single run, single standby, single sleep
  assign volt_wr       = {wr_single_sleep, wr_single_stby, wr_single_run, wr_pair_sleep};
  assign volt_code_bus = {single_sleep_volt_code, single_standby_volt_code,
                          single_run_volt_code, pair_sleep_volt_code};

  // Millivolt values are computed from the write data so they change on the
  // same edge as the code, rather than one cycle behind it
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : gen_volt
      reg [10:0] mv;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mv <= `BPC_VBASE_MV;
        end else if (volt_wr[i]) begin
          mv <= `BPC_VBASE_MV + `BPC_VSTEP_MV * {5'h00, pwdata[5:0]};
        end
      end
      assign volt_mv_bus[i*11 +: 11] = mv;
      // Flags unsupported set points; the bank still stores them
      assign volt_low[i] = (volt_code_bus[i*6 +: 6] <= `BPC_VLOW_MAX_CODE);
    end
  endgenerate

  assign pair_sleep_mv     = volt_mv_bus[10:0];
  assign single_run_mv     = volt_mv_bus[21:11];
  assign single_standby_mv = volt_mv_bus[32:22];
  assign single_sleep_mv   = volt_mv_bus[43:33];

  assign status_q = {4'h0, volt_low};

  // Read mux; misaligned and unmapped addresses miss
  always @* begin
    hit    = aligned;
    rd_mux = 8'h00;
    case (idx)
      `BPC_IDX_PAIR_SLEEP:   rd_mux = pair_sleep_q;
      `BPC_IDX_PAIR_MODE:    rd_mux = pair_mode_q;
      `BPC_IDX_PAIR_CONF:    rd_mux = pair_conf_q;
      `BPC_IDX_SINGLE_RUN:   rd_mux = single_run_q;
      `BPC_IDX_SINGLE_STBY:  rd_mux = single_stby_q;
      `BPC_IDX_SINGLE_SLEEP: rd_mux = single_sleep_q;
      `BPC_IDX_SINGLE_MODE:  rd_mux = single_mode_q;
      `BPC_IDX_SINGLE_CONF:  rd_mux = single_conf_q;
      `BPC_IDX_STATUS:       rd_mux = status_q;
      default:               hit    = 1'b0;
    endcase
    if (!aligned) begin
      rd_mux = 8'h00;
    end
  end

  // Read data and error are captured in the setup cycle and held through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= {24'h000000, rd_mux};
      pslverr <= ~hit;
    end
  end

endmodule // bpc_config_regs

// *** bpc_config_regs_asserts.sv ***
// Concurrent checks on the buck pair configuration register bank ports
`timescale 1ns/1ps

module bpc_config_regs_asserts (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Watched settings
  input wire [5:0]  pair_sleep_volt_code,
  input wire [10:0] pair_sleep_mv,
  input wire [3:0]  pair_switch_mode_sel,
  input wire        pair_sleep_behaviour,
  input wire        pair_current_limit_sel,
  input wire [1:0]  pair_freq_code,
  input wire [1:0]  pair_phase_code,
  input wire [1:0]  pair_slew_code,
  input wire [5:0]  single_run_volt_code,
  input wire [10:0] single_run_mv,
  input wire [5:0]  single_standby_volt_code,
  input wire [5:0]  single_sleep_volt_code,
  input wire [3:0]  single_switch_mode_sel,
  input wire        single_sleep_behaviour,
  input wire        single_current_limit_sel,
  input wire [1:0]  single_freq_code,
  input wire [1:0]  single_phase_code,
  input wire [1:0]  single_slew_code
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;

  a_pair_volt_wr: assert property (wr && paddr == 8'h88 |=>
    pair_sleep_volt_code == $past(pwdata[5:0])) else $error("pair sleep code not stored");
  a_pair_mode_wr: assert property (wr && paddr == 8'h8C |=>
    pair_switch_mode_sel == $past(pwdata[3:0]) && pair_sleep_behaviour == $past(pwdata[5]))
    else $error("pair mode fields not stored");
  a_pair_conf_wr: assert property (wr && paddr == 8'h90 |=>
    {pair_slew_code, pair_phase_code, pair_freq_code} == $past(pwdata[7:2])
    && pair_current_limit_sel == $past(pwdata[0])) else $error("pair config not stored");
  a_run_volt_wr: assert property (wr && paddr == 8'hB8 |=>
    single_run_volt_code == $past(pwdata[5:0])) else $error("single run code not stored");
  a_stby_volt_wr: assert property (wr && paddr == 8'hBC |=>
    single_standby_volt_code == $past(pwdata[5:0])) else $error("standby code not stored");
  a_sleep_volt_wr: assert property (wr && paddr == 8'hC0 |=>
    single_sleep_volt_code == $past(pwdata[5:0])) else $error("single sleep code not stored");
  a_single_mode_wr: assert property (wr && paddr == 8'hC4 |=>
    single_switch_mode_sel == $past(pwdata[3:0]) && single_sleep_behaviour == $past(pwdata[5]))
    else $error("single mode fields not stored");
  a_single_conf_wr: assert property (wr && paddr == 8'hC8 |=>
    {single_slew_code, single_phase_code, single_freq_code} == $past(pwdata[7:2])
    && single_current_limit_sel == $past(pwdata[0])) else $error("single config not stored");
  a_pair_mv_map: assert property (
    pair_sleep_mv == 11'h12C + 11'h019 * pair_sleep_volt_code) else $error("pair mv wrong");
  a_run_mv_map: assert property (
    single_run_mv == 11'h12C + 11'h019 * single_run_volt_code) else $error("run mv wrong");
  a_volt_rd_mask: assert property (psel && !penable && !pwrite && paddr == 8'h88 |=>
    prdata == {26'h0, pair_sleep_volt_code}) else $error("pair sleep read-back wrong");
  a_bad_addr_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=>
    pslverr && prdata == 32'h0) else $error("misaligned access not refused");
  a_conf_hold: assert property (!wr |=>
    $stable({pair_slew_code, pair_phase_code, pair_freq_code, pair_current_limit_sel}))
    else $error("pair config changed without a write");

  c_conf_write: cover property (wr && paddr == 8'h90);
  c_bad_addr: cover property (psel && penable && pslverr);
  c_back_to_back: cover property (wr ##1 psel && !penable);
  c_status_read: cover property (psel && !penable && !pwrite && paddr == 8'hCC);
endmodule // bpc_config_regs_asserts

bind bpc_config_regs bpc_config_regs_asserts u_bpc_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pslverr, .pair_sleep_volt_code, .pair_sleep_mv,
  .pair_switch_mode_sel, .pair_sleep_behaviour, .pair_current_limit_sel, .pair_freq_code,
  .pair_phase_code, .pair_slew_code, .single_run_volt_code, .single_run_mv,
  .single_standby_volt_code, .single_sleep_volt_code, .single_switch_mode_sel,
  .single_sleep_behaviour, .single_current_limit_sel, .single_freq_code, .single_phase_code,
  .single_slew_code);

// *** test_buck_pair_config_regs.sv ***
// Self-checking bench for the buck pair configuration register bank
`timescale 1ns/1ps

module test_buck_pair_config_regs;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire         pready, pslverr, pair_sleep_behaviour, pair_current_limit_sel;
  wire         single_sleep_behaviour, single_current_limit_sel;
  wire  [31:0] prdata;
  wire  [5:0]  pair_sleep_volt_code, single_run_volt_code, single_standby_volt_code;
  wire  [5:0]  single_sleep_volt_code;
  wire  [10:0] pair_sleep_mv, single_run_mv, single_standby_mv, single_sleep_mv;
  wire  [3:0]  pair_switch_mode_sel, single_switch_mode_sel;
  wire  [1:0]  pair_freq_code, pair_phase_code, pair_slew_code;
  wire  [1:0]  single_freq_code, single_phase_code, single_slew_code;
  int          fails = 0;
  int          cmp_count = 0;
  logic [31:0] rd;
  logic        err;
  // Address, write data, expected read-back; last row rewrites pair mode
  logic [23:0] rows [9] = '{24'h88FF3F, 24'h8CFF2F, 24'h90A5A5, 24'hB8D313, 24'hBC2A2A,
                            24'hC0FF3F, 24'hC43525, 24'hC85A5A, 24'h8C1000};

  bpc_config_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .pair_sleep_volt_code, .pair_sleep_mv, .pair_switch_mode_sel,
    .pair_sleep_behaviour, .pair_current_limit_sel, .pair_freq_code, .pair_phase_code,
    .pair_slew_code, .single_run_volt_code, .single_run_mv, .single_standby_volt_code,
    .single_standby_mv, .single_sleep_volt_code, .single_sleep_mv, .single_switch_mode_sel,
    .single_sleep_behaviour, .single_current_limit_sel, .single_freq_code,
    .single_phase_code, .single_slew_code);

  always #50 pclk = ~pclk;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Leaves the bus requested so a following call forms a back-to-back transfer
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
  endtask

  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i][23:16], 1'b1, rows[i][15:8]);
      apb(rows[i][23:16], 1'b0, 8'h00);
      chk("read-back", rd, {24'h0, rows[i][7:0]});
    end
    idle();
    chk("pair config", {pair_slew_code, pair_phase_code, pair_freq_code,
        pair_current_limit_sel}, 32'h53);
    chk("single config", {single_slew_code, single_phase_code, single_freq_code,
        single_current_limit_sel}, 32'h2C);
    chk("modes", {single_sleep_behaviour, single_switch_mode_sel, pair_sleep_behaviour,
        pair_switch_mode_sel}, 32'h2A0);
    chk("mv", {single_run_mv, pair_sleep_mv}, {11'h307, 11'h753});
    chk("stby sleep codes", {single_sleep_volt_code, single_standby_volt_code}, 32'hFEA);
    chk("stby sleep mv", {single_sleep_mv, single_standby_mv}, {11'h753, 11'h546});
    $display("table test done");
    apb(8'h89, 1'b1, 8'h00);
    chk("misaligned error", err, 32'h1);
    apb(8'h80, 1'b0, 8'h00);
    chk("unmapped data", {err, rd[30:0]}, 32'h80000000);
    apb(8'h88, 1'b0, 8'h00);
    chk("kept after refusal", rd, 32'h3F);
    apb(8'hBC, 1'b1, 8'h0C);
    apb(8'hCC, 1'b1, 8'hFF);
    chk("status write error", err, 32'h0);
    apb(8'hCC, 1'b0, 8'h00);
    chk("low set point flag", rd, 32'h04);
    idle();
    $display("refusal test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset mv", single_sleep_mv, 32'h12C);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      apb(rows[i][23:16], 1'b0, 8'h00);
      chk("reset value", rd, 32'h0);
    end
    apb(8'hCC, 1'b0, 8'h00);
    chk("reset status", rd, 32'h0F);
    idle();
    $display("reset test done");
    complete_run();
  end
endmodule // test_buck_pair_config_regs
